//--- design/cdd_dispatch.sv
module cdd_dispatch (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_prim_valid,
  output logic o_prim_ready,
  input wire logic [1:0] i_prim_type,
  input wire logic [cdd_pkg::HANDLES_W-1:0] i_prim_handles,
  input wire logic [cdd_pkg::OCS_W-1:0] i_prim_outcodes,
  input wire logic [1:0] i_clip_route_select,
  input wire logic i_guardband_enable,
  input wire logic [cdd_pkg::UCF_W-1:0] i_user_clip_enable,
  input wire logic [31:0] i_state_dw0,
  input wire logic [31:0] i_state_dw1,
  output logic o_pass_valid,
  input wire logic i_pass_ready,
  output logic [1:0] o_pass_type,
  output logic [cdd_pkg::HANDLES_W-1:0] o_pass_handles,
  output logic o_spawn_valid,
  input wire logic i_spawn_ready,
  output logic [1:0] o_spawn_type,
  output logic [cdd_pkg::HANDLES_W-1:0] o_spawn_handles,
  output logic [cdd_pkg::KPTR_W-1:0] o_kernel_ptr,
  output logic o_single_flow,
  output logic [7:0] o_prefetch_count,
  output logic o_high_priority,
  output logic o_fp_alternate,
  output logic [cdd_pkg::EXC_W-1:0] o_thread_exc,
  output logic o_release_valid,
  output logic [cdd_pkg::HANDLES_W-1:0] o_release_handles,
  output logic o_discard_valid,
  output logic o_spf_error
);
  import cdd_pkg::*;

  ////////////////////////////////////////////////////////////
  // Helper functions

  // Vertex count by topology; rectangle corner four never looked at
  function automatic logic vtx_active(input logic [1:0] ptype,
                                      input int v);
    logic act;
    act = 1'b0;
    case (ptype)
      PRIM_TRI, PRIM_RECTANGLE_LIST: act = (v < 3);
      PRIM_LINE: act = (v < 2);
      PRIM_POINT: act = (v < 1);
      default: act = 1'b0;
    endcase
    return act;
  endfunction : vtx_active

  // Outcode of one vertex out of the packed set
  function automatic logic [OC_W-1:0] vtx_oc(
    input logic [OCS_W-1:0] ocs, input int v);
    logic [OC_W-1:0] oc;
    oc = ocs[v*OC_W +: OC_W];
    return oc;
  endfunction : vtx_oc

  ////////////////////////////////////////////////////////////
  // Input buffer

  localparam int TYPE_LSB = 0;
  localparam int HND_LSB = 2;
  localparam int OCS_LSB = 2 + HANDLES_W;

  logic [PRIM_W-1:0] in_word;
  logic [PRIM_W-1:0] head;
  logic head_valid;
  logic head_pop;
  logic [1:0] head_type;
  logic [HANDLES_W-1:0] head_hnd;
  logic [OCS_W-1:0] head_ocs;

  assign in_word = {i_prim_outcodes, i_prim_handles, i_prim_type};
  assign head_type = head[TYPE_LSB +: 2];
  assign head_hnd = head[HND_LSB +: HANDLES_W];
  assign head_ocs = head[OCS_LSB +: OCS_W];

  cdd_fifo #(
    .WIDTH(PRIM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_prim_valid),
    .o_in_ready(o_prim_ready),
    .i_in_data(in_word),
    .o_out_valid(head_valid),
    .i_out_ready(head_pop),
    .o_out_data(head)
  );

  ////////////////////////////////////////////////////////////
  // Clip determination

  logic [OC_W-1:0] oc_and;
  logic [OC_W-1:0] oc_or;
  logic rej;
  logic acc;
  logic [3:0] acc_xy;
  cdd_route_e route;

  assign route = cdd_route_e'(i_clip_route_select);

  // Combine outcodes across active vertices
  always_comb begin
    oc_and = '1;
    oc_or = '0;
    for (int v = 0; v < VTX_NUM; v++) begin
      if (vtx_active(head_type, v)) begin
        oc_and = oc_and & vtx_oc(head_ocs, v);
        oc_or = oc_or | vtx_oc(head_ocs, v);
      end
    end
  end

  // Reject on viewport XY or on enabled user planes
  assign rej = (oc_and[OC_XY_LSB +: 4] != 4'h0) ||
               ((oc_and[OC_UCF_LSB +: UCF_W] & i_user_clip_enable)
                != '0);

  // Guardband outcodes replace viewport XY for accept
  assign acc_xy = i_guardband_enable ? oc_or[OC_GB_LSB +: 4]
                                     : oc_or[OC_XY_LSB +: 4];
  assign acc = (acc_xy == 4'h0) &&
               (oc_or[OC_Z_LSB +: 2] == 2'h0) &&
               ((oc_or[OC_UCF_LSB +: UCF_W] & i_user_clip_enable)
                == '0);

  logic go_discard;
  logic go_pass;
  logic go_spawn;

  // Outcome under the selected route
  always_comb begin
    go_discard = 1'b0;
    go_pass = 1'b0;
    go_spawn = 1'b0;
    case (route)
      ROUTE_ALL: go_spawn = 1'b1;
      ROUTE_NON_REJECTED: begin
        go_discard = rej;
        go_spawn = !rej;
      end
      default: begin
        go_discard = rej;
        go_pass = !rej && acc;
        go_spawn = !rej && !acc;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // Sequencer

  cdd_state_e state_q;
  logic pass_done;
  logic spawn_done;

  assign head_pop = head_valid && (state_q == ST_IDLE);
  assign pass_done = o_pass_valid && i_pass_ready;
  assign spawn_done = o_spawn_valid && i_spawn_ready;

  // One object in flight toward pass or spawn
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (head_pop && go_pass) begin
            state_q <= ST_PASS;
          end else if (head_pop && go_spawn) begin
            state_q <= ST_SPAWN;
          end
        end
        ST_PASS: begin
          if (pass_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SPAWN: begin
          if (spawn_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Downstream pass output
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pass_valid <= 1'b0;
      o_pass_type <= 2'h0;
      o_pass_handles <= '0;
    end else if (head_pop && go_pass) begin
      o_pass_valid <= 1'b1;
      o_pass_type <= head_type;
      o_pass_handles <= head_hnd;
    end else if (pass_done) begin
      o_pass_valid <= 1'b0;
    end
  end

  // Thread dispatch request and its state fields
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_spawn_valid <= 1'b0;
      o_spawn_type <= 2'h0;
      o_spawn_handles <= '0;
      o_kernel_ptr <= '0;
      o_single_flow <= 1'b1;
      o_prefetch_count <= 8'h00;
      o_high_priority <= 1'b0;
      o_fp_alternate <= 1'b0;
      o_thread_exc <= '0;
    end else if (head_pop && go_spawn) begin
      o_spawn_valid <= 1'b1;
      o_spawn_type <= head_type;
      o_spawn_handles <= head_hnd;
      o_kernel_ptr <= i_state_dw0[KPTR_MSB:KPTR_LSB];
      o_single_flow <= i_state_dw1[SPF_BIT];
      o_prefetch_count <= i_state_dw1[BTC_MSB:BTC_LSB];
      o_high_priority <= i_state_dw1[PRIO_BIT] &&
                         HIGH_PRIO_SUPPORTED;
      o_fp_alternate <= i_state_dw1[FPM_BIT];
      o_thread_exc <= '0;
      o_thread_exc[EXC_ILL_POS] <= i_state_dw1[ILL_BIT];
      o_thread_exc[EXC_MSK_POS] <= i_state_dw1[MSK_BIT];
    end else if (spawn_done) begin
      o_spawn_valid <= 1'b0;
    end
  end

  // Entry release on spawn or discard
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_release_valid <= 1'b0;
      o_release_handles <= '0;
      o_discard_valid <= 1'b0;
    end else begin
      o_release_valid <= spawn_done || (head_pop && go_discard);
      o_discard_valid <= head_pop && go_discard;
      if (spawn_done) begin
        o_release_handles <= o_spawn_handles;
      end else if (head_pop && go_discard) begin
        o_release_handles <= head_hnd;
      end
    end
  end

  // Sticky flag for a reserved single flow setting
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_spf_error <= 1'b0;
    end else if (head_pop && go_spawn && !i_state_dw1[SPF_BIT]) begin
      o_spf_error <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks

  AST_REJECT_DISCARD :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_pop && rej && route != ROUTE_ALL |=>
      o_discard_valid && o_release_valid && !$rose(o_pass_valid))
  else $error("rejected object not discarded");

  AST_ACCEPT_PASS :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_pop && route == ROUTE_NORMAL && !rej && acc |=>
      o_pass_valid && o_pass_handles == $past(head_hnd))
  else $error("accepted object not passed");

  AST_ROUTE_ALL :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_pop && route == ROUTE_ALL |=> o_spawn_valid && !o_discard_valid)
  else $error("route all did not spawn");

  AST_CLIP_SPAWN :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_pop && route == ROUTE_NORMAL && !rej && !acc |=>
      o_spawn_valid && !o_pass_valid)
  else $error("clip object not spawned");

  AST_RELEASE_SPAWN :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_spawn_valid && i_spawn_ready |=>
      o_release_valid && o_release_handles == $past(o_spawn_handles))
  else $error("spawn did not release entries");

  AST_KERNEL_PTR :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_kernel_ptr == $past(i_state_dw0[KPTR_MSB:KPTR_LSB]))
  else $error("kernel pointer wrong");

  AST_PRIORITY :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_high_priority == $past(i_state_dw1[PRIO_BIT]))
  else $error("priority wrong");

  AST_FP_MODE :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_fp_alternate == $past(i_state_dw1[FPM_BIT]))
  else $error("float mode wrong");

  AST_ILL_EXC :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_thread_exc[EXC_ILL_POS] == $past(i_state_dw1[ILL_BIT]))
  else $error("illegal opcode enable wrong");

  AST_MSK_EXC :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_thread_exc[EXC_MSK_POS] == $past(i_state_dw1[MSK_BIT]))
  else $error("mask stack enable wrong");

  AST_SPF_FLAG :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) && !o_single_flow |-> o_spf_error)
  else $error("reserved single flow not flagged");

  AST_PREFETCH :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $rose(o_spawn_valid) |->
      o_prefetch_count == $past(i_state_dw1[BTC_MSB:BTC_LSB]))
  else $error("prefetch count wrong");

  AST_LINE_THIRD_IGNORED :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    head_valid && head_type == PRIM_LINE |->
      oc_or == (vtx_oc(head_ocs, 0) | vtx_oc(head_ocs, 1)))
  else $error("line uses third vertex");
endmodule : cdd_dispatch

//--- design/cdd_fifo.sv
module cdd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////
  // Handshakes and occupancy
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Count and registered full/empty flags
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_in_ready <= (cnt_d != CNT_FULL);
      o_out_valid <= (cnt_d != '0);
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
      end
    end
  end

  // Storage
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  AST_FIFO_NO_OVERRUN :
  assert property (@(posedge i_ref_clk) disable iff (i_rst)
    cnt_q == CNT_FULL |-> !o_in_ready)
  else $error("fifo accepts while full");
endmodule : cdd_fifo

//--- design/cdd_pkg.sv
package cdd_pkg;
  // Stream geometry
  localparam int VTX_NUM = 3;
  localparam int HANDLE_W = 8;
  localparam int HANDLES_W = VTX_NUM * HANDLE_W;
  localparam int OC_W = 18;
  localparam int OCS_W = VTX_NUM * OC_W;
  localparam int PRIM_W = 2 + HANDLES_W + OCS_W;
  localparam int FIFO_DEPTH = 8;

  // Per-vertex outcode field positions
  localparam int OC_XY_LSB = 0;
  localparam int OC_GB_LSB = 4;
  localparam int OC_Z_LSB = 8;
  localparam int OC_UCF_LSB = 10;
  localparam int UCF_W = 8;

  // Dispatch state word 0 and word 1 fields
  localparam int KPTR_MSB = 31;
  localparam int KPTR_LSB = 6;
  localparam int KPTR_W = KPTR_MSB - KPTR_LSB + 1;
  localparam int SPF_BIT = 31;
  localparam int BTC_MSB = 25;
  localparam int BTC_LSB = 18;
  localparam int PRIO_BIT = 17;
  localparam int FPM_BIT = 16;
  localparam int ILL_BIT = 13;
  localparam int MSK_BIT = 11;

  // Thread exception control layout
  localparam int EXC_W = 4;
  localparam int EXC_ILL_POS = 1;
  localparam int EXC_MSK_POS = 2;

  // High priority dispatch exists on this variant
  localparam logic HIGH_PRIO_SUPPORTED = 1'b1;

  typedef enum logic [1:0] {
    PRIM_TRI = 2'h0,
    PRIM_LINE = 2'h1,
    PRIM_RECTANGLE_LIST = 2'h2,
    PRIM_POINT = 2'h3
  } cdd_prim_e;

  typedef enum logic [1:0] {
    ROUTE_NORMAL = 2'h0,
    ROUTE_ALL = 2'h1,
    ROUTE_NON_REJECTED = 2'h2
  } cdd_route_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PASS = 2'b01,
    ST_SPAWN = 2'b10
  } cdd_state_e;
endpackage : cdd_pkg

//--- verif/cdd_far_model.sv
module cdd_far_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_mode,
  input wire logic i_pass_valid,
  input wire logic [25:0] i_pass_word,
  output logic o_pass_ready,
  input wire logic i_spawn_valid,
  input wire logic [66:0] i_spawn_word,
  output logic o_spawn_ready,
  input wire logic i_release_valid,
  input wire logic [23:0] i_release_handles,
  input wire logic i_discard_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [25:0] pass_q[$];
  logic [66:0] spawn_q[$];
  logic [23:0] rel_q[$];
  int n_disc = 0;
  int n_bad = 0;
  logic [1:0] tick_q = 2'h0;
  logic pw_q = 1'b0;
  logic sw_q = 1'b0;
  logic [25:0] pword_q;
  logic [66:0] sword_q;
  ////////////////////////////////////////
  // Mode 0 prompt, 1 one cycle in four, 2 stopped
  always @(posedge i_ref_clk) tick_q <= tick_q + 2'h1;
  assign o_pass_ready = i_mode == 2'h0 || (i_mode == 2'h1 && tick_q == 2'h3);
  assign o_spawn_ready = i_mode == 2'h0 || (i_mode == 2'h1 && tick_q == 2'h1);
  // Log every completed transfer and pulse
  always @(posedge i_ref_clk) begin
    if (i_pass_valid && o_pass_ready) pass_q.push_back(i_pass_word);
    if (i_spawn_valid && o_spawn_ready) spawn_q.push_back(i_spawn_word);
    if (i_release_valid) rel_q.push_back(i_release_handles);
    if (i_discard_valid) n_disc++;
  end
  // An offer refused must stand unchanged
  always @(posedge i_ref_clk) begin
    if (pw_q && {i_pass_valid, i_pass_word} !== {1'b1, pword_q}) n_bad++;
    if (sw_q && {i_spawn_valid, i_spawn_word} !== {1'b1, sword_q}) n_bad++;
    pw_q <= !i_rst && i_pass_valid && !o_pass_ready;
    sw_q <= !i_rst && i_spawn_valid && !o_spawn_ready;
    pword_q <= i_pass_word;
    sword_q <= i_spawn_word;
  end
endmodule : cdd_far_model

//--- verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cdd_pkg::*;
  // Vertex outcodes: inside, out of XY and guardband, out of XY only
  localparam logic [17:0] V_IN = 18'h00000;
  localparam logic [17:0] V_OUT = 18'h00011;
  localparam logic [17:0] V_OUT2 = 18'h00022;
  localparam logic [17:0] V_GB = 18'h00001;
  localparam logic [17:0] V_Z = 18'h00100;
  localparam logic [17:0] V_U = 18'h00400;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_prim_valid = 1'b0;
  logic [1:0] i_prim_type = 2'h0;
  logic [HANDLES_W-1:0] i_prim_handles = 24'h0;
  logic [OCS_W-1:0] i_prim_outcodes = 54'h0;
  logic [1:0] i_clip_route_select = 2'h0;
  logic i_guardband_enable = 1'b1;
  logic [UCF_W-1:0] i_user_clip_enable = 8'hFF;
  logic [31:0] i_state_dw0 = 32'h0;
  logic [31:0] i_state_dw1 = 32'h80000000;
  logic [1:0] far_mode = 2'h0;
  logic i_pass_ready, i_spawn_ready, o_prim_ready, o_pass_valid;
  logic o_spawn_valid, o_single_flow, o_high_priority, o_fp_alternate;
  logic o_release_valid, o_discard_valid, o_spf_error;
  logic [1:0] o_pass_type, o_spawn_type;
  logic [HANDLES_W-1:0] o_pass_handles, o_spawn_handles, o_release_handles;
  logic [KPTR_W-1:0] o_kernel_ptr;
  logic [7:0] o_prefetch_count;
  logic [EXC_W-1:0] o_thread_exc;
  logic [7:0] hseq = 8'h10;
  logic [23:0] h_last;
  int error_cnt = 0;
  int n_compared = 0;
  ////////////////////////////////////////
  cdd_dispatch u_dut (.i_ref_clk, .i_rst, .i_prim_valid, .o_prim_ready,
    .i_prim_type, .i_prim_handles, .i_prim_outcodes, .i_clip_route_select,
    .i_guardband_enable, .i_user_clip_enable, .i_state_dw0, .i_state_dw1,
    .o_pass_valid, .i_pass_ready, .o_pass_type, .o_pass_handles,
    .o_spawn_valid, .i_spawn_ready, .o_spawn_type, .o_spawn_handles,
    .o_kernel_ptr, .o_single_flow, .o_prefetch_count, .o_high_priority,
    .o_fp_alternate, .o_thread_exc, .o_release_valid, .o_release_handles,
    .o_discard_valid, .o_spf_error);
  cdd_far_model u_far (.i_ref_clk, .i_rst, .i_mode(far_mode),
    .i_pass_valid(o_pass_valid), .i_pass_word({o_pass_type, o_pass_handles}),
    .o_pass_ready(i_pass_ready), .i_spawn_valid(o_spawn_valid),
    .i_spawn_word({o_spawn_type, o_spawn_handles, o_kernel_ptr, o_single_flow,
      o_prefetch_count, o_high_priority, o_fp_alternate, o_thread_exc}),
    .o_spawn_ready(i_spawn_ready), .i_release_valid(o_release_valid),
    .i_release_handles(o_release_handles), .i_discard_valid(o_discard_valid));
  // Clock
  always #5 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // Offer one object and hold it until taken
  task automatic push(input logic [1:0] ty, input logic [OCS_W-1:0] oc);
    int k;
    @(negedge i_ref_clk);
    i_prim_valid = 1'b1;
    i_prim_type = ty;
    i_prim_outcodes = oc;
    h_last = {hseq + 8'h2, hseq + 8'h1, hseq};
    i_prim_handles = h_last;
    hseq = hseq + 8'h3;
    for (k = 0; k < 50 && o_prim_ready !== 1'b1; k++) @(negedge i_ref_clk);
    @(posedge i_ref_clk);
    #1;
  endtask : push
  // Fate of one object: 0 discard, 1 pass, 2 spawn
  task automatic one(input logic [1:0] ty, input logic [17:0] a, b, c,
                     input int exp);
    int np, ns, nr, nd, k;
    np = u_far.pass_q.size();
    ns = u_far.spawn_q.size();
    nr = u_far.rel_q.size();
    nd = u_far.n_disc;
    push(ty, {c, b, a});
    @(negedge i_ref_clk);
    i_prim_valid = 1'b0;
    for (k = 0; k < 20 && u_far.pass_q.size() + u_far.spawn_q.size()
         + u_far.n_disc == np + ns + nd; k++) @(negedge i_ref_clk);
    repeat (2) @(negedge i_ref_clk);
    chk(u_far.pass_q.size() == np + (exp == 1), "pass count");
    chk(u_far.spawn_q.size() == ns + (exp == 2), "spawn count");
    chk(u_far.n_disc == nd + (exp == 0), "discard count");
    chk(u_far.rel_q.size() == nr + (exp != 1), "release count");
    if (exp == 1) chk(u_far.pass_q[np] === {ty, h_last}, "pass");
    if (exp == 2)
      chk(u_far.spawn_q[ns][66:41] === {ty, h_last}, "spawn");
    if (exp != 1) chk(u_far.rel_q[nr] === h_last, "release");
  endtask : one
  ////////////////////////////////////////
  // Normal routing over every primitive kind
  task automatic t_classes();
    one(PRIM_TRI, V_OUT, V_OUT, V_OUT, 0);
    one(PRIM_TRI, V_IN, V_IN, V_IN, 1);
    one(PRIM_TRI, V_GB, V_IN, V_IN, 1);
    one(PRIM_TRI, V_OUT, V_OUT2, V_OUT, 2);
    one(PRIM_TRI, V_Z, V_IN, V_IN, 2);
    one(PRIM_TRI, V_U, V_IN, V_IN, 2);
    one(PRIM_TRI, V_U, V_U, V_U, 0);
    one(PRIM_RECTANGLE_LIST, V_OUT, V_OUT, V_OUT, 0);
    one(PRIM_RECTANGLE_LIST, V_GB, V_IN, V_IN, 1);
    one(PRIM_RECTANGLE_LIST, V_IN, V_IN, V_OUT, 2);
    one(PRIM_LINE, V_OUT, V_OUT, V_IN, 0);
    one(PRIM_LINE, V_IN, V_GB, V_OUT, 1);
    one(PRIM_LINE, V_OUT, V_IN, V_IN, 2);
    one(PRIM_POINT, V_OUT, V_IN, V_IN, 0);
    one(PRIM_POINT, V_IN, V_OUT, V_OUT, 1);
    @(negedge i_ref_clk);
    i_user_clip_enable = 8'hFE;
    one(PRIM_TRI, V_U, V_U, V_U, 1);
    @(negedge i_ref_clk);
    i_guardband_enable = 1'b0;
    one(PRIM_TRI, V_GB, V_IN, V_IN, 2);
    one(PRIM_POINT, V_GB, V_IN, V_IN, 0);
    @(negedge i_ref_clk);
    i_guardband_enable = 1'b1;
    i_user_clip_enable = 8'hFF;
  endtask : t_classes
  // Every route code with an inside and a rejected object
  task automatic t_route();
    int ein[4] = '{1, 2, 2, 1};
    int eout[4] = '{0, 2, 0, 0};
    for (int r = 0; r < 4; r++) begin
      @(negedge i_ref_clk);
      i_clip_route_select = 2'(r);
      one(PRIM_TRI, V_IN, V_IN, V_IN, ein[r]);
      one(PRIM_TRI, V_OUT, V_OUT, V_OUT, eout[r]);
    end
    @(negedge i_ref_clk);
    i_clip_route_select = 2'h0;
  endtask : t_route
  // Dispatch fields ride with each spawn; slow dispatcher
  task automatic t_state();
    logic [31:0] w0[3] = '{32'hFFFFFFC0, 32'h1234567F, 32'h00000040};
    logic [31:0] w1[3] = '{32'h80022800, 32'h83FD0000, 32'h00000000};
    logic [40:0] ex;
    far_mode = 2'h1;
    for (int i = 0; i < 3; i++) begin
      @(negedge i_ref_clk);
      i_state_dw0 = w0[i];
      i_state_dw1 = w1[i];
      ex = {w0[i][31:6], w1[i][31], w1[i][25:18],
            HIGH_PRIO_SUPPORTED & w1[i][17], w1[i][16],
            1'b0, w1[i][11], w1[i][13], 1'b0};
      one(PRIM_TRI, V_OUT, V_IN, V_IN, 2);
      chk(u_far.spawn_q[$][40:15] === ex[40:15], "kernel ptr");
      chk(u_far.spawn_q[$][14] === ex[14], "single flow");
      chk(u_far.spawn_q[$][13:6] === ex[13:6], "prefetch");
      chk(u_far.spawn_q[$][5] === ex[5], "priority");
      chk(u_far.spawn_q[$][4] === ex[4], "float mode");
      chk(u_far.spawn_q[$][1:0] === ex[1:0], "illegal op");
      chk(u_far.spawn_q[$][3:2] === ex[3:2], "mask stack");
      chk(o_spf_error === (i == 2), "single flow flag");
    end
    @(negedge i_ref_clk);
    i_state_dw1 = 32'h80000000;
    one(PRIM_TRI, V_OUT, V_IN, V_IN, 2);
    chk(o_spf_error === 1'b1, "flag not sticky");
    far_mode = 2'h0;
  endtask : t_state
  // Fill against a stopped receiver, then drain slowly in order
  task automatic t_fifo();
    int n, np, i;
    logic [7:0] b0, b;
    logic [23:0] hw;
    np = u_far.pass_q.size();
    b0 = hseq;
    n = 0;
    far_mode = 2'h2;
    while (n < 16 && o_prim_ready === 1'b1) begin
      push(PRIM_TRI, 54'h0);
      n++;
    end
    chk(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2, "queue depth");
    @(negedge i_ref_clk);
    i_prim_valid = 1'b0;
    far_mode = 2'h1;
    for (i = 0; i < 400 && u_far.pass_q.size() < np + n; i++) begin
      @(negedge i_ref_clk);
    end
    chk(u_far.pass_q.size() == np + n, "drain");
    chk(o_prim_ready === 1'b1, "ready after drain");
    for (i = 0; i < n; i++) begin
      b = b0 + 8'(3 * i);
      hw = {b + 8'h2, b + 8'h1, b};
      chk(u_far.pass_q[np + i] === {PRIM_TRI, hw}, "order");
    end
    far_mode = 2'h0;
  endtask : t_fifo
  // Values held while reset is asserted
  task automatic t_reset();
    chk(o_prim_ready === 1'b1 && o_pass_valid === 1'b0 &&
        o_spawn_valid === 1'b0 && o_release_valid === 1'b0 &&
        o_discard_valid === 1'b0 && o_single_flow === 1'b1 &&
        o_spf_error === 1'b0, "reset values");
  endtask : t_reset
  ////////////////////////////////////////
  // Main sequence, with a second reset to clear the sticky flag
  initial begin
    repeat (20) @(negedge i_ref_clk);
    t_reset();
    i_rst = 1'b0;
    t_classes();
    t_route();
    t_state();
    t_fifo();
    chk(u_far.n_bad == 0, "refused offer moved");
    @(negedge i_ref_clk);
    i_rst = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    t_reset();
    i_rst = 1'b0;
    one(PRIM_TRI, V_IN, V_IN, V_IN, 1);
    give_verdict();
  end
  // Cut a hang short
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
